// ---- logic/bsk_ctrl.sv ----
// bank switch, clock out divider, interrupt ack gating and bus keeper control
// assumes one clock pclk, async active low reset, apb register access, and a
// core that holds each request until accepted
//
// Operation
// - one idle cycle on 32K bank crossing
// - control register mapped at index 29h
// - mode 0: idle only on bank, space or page change
// - mode 1: start, read, trail per read
// - clock out divided by field plus one, by two at field 0
// - intack off bit resets 1, silences output
// - host keeper bit, or wide port on
// - data keeper bit enables data keeper
// - remember msb of last prog/data access
// - msb change holds strobe off one cycle
// - each read overwrites stored msb
// - matching msb gives plain read cycle
// - same bank reads run back to back
// - prog/data space swap inserts one cycle
// - program page change inserts one cycle
// - keepers follow bits; address and host keepers also follow wide pin
`timescale 1ns/1ns
`include "bsk_consts.svh"
module bsk_ctrl #(
  parameter int ADDR_W = 23
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core access request
  input wire bsk_pkg::bsk_req_s core_req,
  input wire logic core_intack,
  output logic req_accept,
  // external memory side
  output logic memory_strobe_n,
  output logic [ADDR_W-1:0] ext_addr,
  output logic clock_out_pin,
  output logic interrupt_ack_out,
  // keepers
  input wire logic wide_host_port_sel,
  output bsk_pkg::bsk_keep_s keep_en
);
  // the page field needs at least one bit above the bank msb
  if (ADDR_W < 17 || ADDR_W > 23) begin : g_bad_width
    $error("bsk_ctrl: ADDR_W out of range");
  end

  // -----------------------------------------------------------------------
  // control register
  // -----------------------------------------------------------------------
  logic back_to_back_bank_mode_ff;
  logic [1:0] clock_out_divider_ff;
  logic intack_output_off_ff;
  logic host_bus_keeper_en_ff;
  logic data_bus_keeper_en_ff;
  logic wide_sync1_ff;
  logic wide_sync2_ff;
  logic wr_hit;
  logic rd_hit;
  logic addr_hit;

  assign addr_hit = (paddr == `BSK_REG_ADDR);
  assign wr_hit = psel && penable && pwrite && addr_hit;
  assign rd_hit = psel && !penable && !pwrite && addr_hit;

  // register fields; reserved bits have no storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      back_to_back_bank_mode_ff <= 1'b0;
      clock_out_divider_ff <= `BSK_RST_DIV;
      intack_output_off_ff <= `BSK_RST_INTACK_OFF;
      host_bus_keeper_en_ff <= 1'b0;
      data_bus_keeper_en_ff <= 1'b0;
    end else if (wr_hit) begin
      back_to_back_bank_mode_ff <= pwdata[`BSK_BIT_MODE];
      clock_out_divider_ff <= pwdata[`BSK_BIT_DIV_HI:`BSK_BIT_DIV_LO];
      intack_output_off_ff <= pwdata[`BSK_BIT_INTACK_OFF];
      host_bus_keeper_en_ff <= pwdata[`BSK_BIT_HOST_KEEP];
      data_bus_keeper_en_ff <= pwdata[`BSK_BIT_DATA_KEEP];
    end
  end

  // apb answer: one access cycle, zero wait; unmapped reads zero, no error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (rd_hit) begin
        prdata <= {16'h0000, back_to_back_bank_mode_ff, clock_out_divider_ff,
                   intack_output_off_ff, 9'h000, host_bus_keeper_en_ff,
                   data_bus_keeper_en_ff, 1'b0};
      end else if (psel && !penable) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // -----------------------------------------------------------------------
  // clock out divider
  // -----------------------------------------------------------------------
  logic [1:0] div_cnt_ff;
  logic clk_tick;

  // tick marks the start of each clock out period, each half period at field 0; strobe steps follow it
  assign clk_tick = (div_cnt_ff == clock_out_divider_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= 2'h0;
      clock_out_pin <= 1'b0;
    end else begin
      div_cnt_ff <= clk_tick ? 2'h0 : div_cnt_ff + 2'h1;
      // high for the first half period; field 0 toggles every rising edge
      clock_out_pin <= (clock_out_divider_ff == 2'h0) ? !clock_out_pin
                       : (clk_tick || (div_cnt_ff < (clock_out_divider_ff >> 1)));
    end
  end

  // -----------------------------------------------------------------------
  // access sequencer
  // -----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_ACCESS, ST_TRAIL} bsk_state_e;
  bsk_state_e state_ff;
  logic last_msb_ff;
  bsk_pkg::bsk_space_e last_space_ff;
  logic [ADDR_W-1:16] last_page_ff;
  bsk_pkg::bsk_req_s cur_ff;
  logic need_gap;
  logic req_msb;

  function automatic logic page_of(input logic [ADDR_W-1:0] a, input int b);
    return a[b];
  endfunction

  assign req_msb = page_of(core_req.addr[ADDR_W-1:0], `BSK_BANK_MSB);
  // a gap is due on bank change, space swap or program page change
  assign need_gap = core_req.is_read && (
      (req_msb != last_msb_ff)
      || (last_space_ff != bsk_pkg::BSK_SPACE_NONE &&
          (core_req.is_prog ? bsk_pkg::BSK_SPACE_PROG : bsk_pkg::BSK_SPACE_DATA)
          != last_space_ff)
      || (core_req.is_prog && last_space_ff == bsk_pkg::BSK_SPACE_PROG &&
          core_req.addr[ADDR_W-1:16] != last_page_ff));

  // steps advance once per divider tick, so strobe gaps last one clock out period, half of one at field 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      cur_ff <= '0;
      req_accept <= 1'b0;
      memory_strobe_n <= 1'b1;
      ext_addr <= '0;
    end else begin
      req_accept <= 1'b0;
      if (clk_tick) begin
        unique case (state_ff)
          ST_IDLE: begin
            memory_strobe_n <= 1'b1;
            if (core_req.valid && !req_accept) begin
              cur_ff <= core_req;
              ext_addr <= core_req.addr[ADDR_W-1:0]; // address moves during gap
              if ((back_to_back_bank_mode_ff && core_req.is_read) || need_gap) begin
                state_ff <= ST_GAP;
              end else begin
                state_ff <= ST_ACCESS;
                memory_strobe_n <= 1'b0;
              end
            end
          end
          ST_GAP: begin
            state_ff <= ST_ACCESS;
            memory_strobe_n <= 1'b0;
          end
          ST_ACCESS: begin
            memory_strobe_n <= 1'b1;
            req_accept <= 1'b1;
            state_ff <= (back_to_back_bank_mode_ff && cur_ff.is_read) ? ST_TRAIL
                                                                      : ST_IDLE;
          end
          ST_TRAIL: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // history of the last program or data access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_msb_ff <= 1'b0;
      last_space_ff <= bsk_pkg::BSK_SPACE_NONE;
      last_page_ff <= '0;
    end else if (clk_tick && state_ff == ST_ACCESS) begin
      last_msb_ff <= page_of(cur_ff.addr[ADDR_W-1:0], `BSK_BANK_MSB);
      last_space_ff <= cur_ff.is_prog ? bsk_pkg::BSK_SPACE_PROG : bsk_pkg::BSK_SPACE_DATA;
      last_page_ff <= cur_ff.addr[ADDR_W-1:16];
    end
  end

  // -----------------------------------------------------------------------
  // interrupt ack and keepers
  // -----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_sync1_ff <= 1'b0;
      wide_sync2_ff <= 1'b0;
      interrupt_ack_out <= 1'b1;
      keep_en <= '0;
    end else begin
      wide_sync1_ff <= wide_host_port_sel;
      wide_sync2_ff <= wide_sync1_ff;
      // active low ack held high while switched off
      interrupt_ack_out <= intack_output_off_ff ? 1'b1 : !core_intack;
      keep_en.data_keep <= data_bus_keeper_en_ff;
      keep_en.addr_keep <= wide_sync2_ff || host_bus_keeper_en_ff;
      keep_en.host_keep <= wide_sync2_ff || host_bus_keeper_en_ff;
    end
  end

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  // gap step: strobe held off while the new address settles
  sequence s_gap_step;
    state_ff == ST_GAP && memory_strobe_n;
  endsequence

  // read step: strobe driven low while the access runs
  sequence s_read_step;
    state_ff == ST_ACCESS && !memory_strobe_n;
  endsequence

  // idle tick with a pending request that the sequencer will take
  sequence s_take;
    clk_tick && state_ff == ST_IDLE && core_req.valid && !req_accept;
  endsequence

  a_reg_write_mode: assert property (@(posedge pclk) disable iff (!presetn)
    wr_hit |=> back_to_back_bank_mode_ff == $past(pwdata[15]))
    else $error("mode bit not written");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[11:3] == 9'h000 && prdata[0] == 1'b0)
    else $error("reserved bits not zero");
  a_div_period: assert property (@(posedge pclk) disable iff (!presetn)
    clk_tick |=> div_cnt_ff == 2'h0)
    else $error("divider period wrong");
  a_intack_off: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 $past(intack_output_off_ff) |-> interrupt_ack_out)
    else $error("ack not silenced");
  a_data_keeper: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 keep_en.data_keep == $past(data_bus_keeper_en_ff))
    else $error("data keeper wrong");
  a_host_keeper: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 keep_en.host_keep == ($past(host_bus_keeper_en_ff) || $past(wide_sync2_ff)))
    else $error("host keeper wrong");
  a_gap_inserted: assert property (@(posedge pclk) disable iff (!presetn)
    (s_take ##0 need_gap) |=> s_gap_step)
    else $error("no gap on bank change");
  a_no_gap_same: assert property (@(posedge pclk) disable iff (!presetn)
    (s_take ##0 (!need_gap && !back_to_back_bank_mode_ff)) |=> s_read_step)
    else $error("gap on same bank");
  a_msb_record: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_tick && state_ff == ST_ACCESS) |=> last_msb_ff == cur_ff.addr[15])
    else $error("msb not recorded");
  a_trail_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_tick && state_ff == ST_ACCESS && back_to_back_bank_mode_ff && cur_ff.is_read)
      |=> state_ff == ST_TRAIL && memory_strobe_n)
    else $error("no trailing cycle");

  // trailing step returns to idle with the strobe still off
  a_trail_done: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_tick && state_ff == ST_TRAIL) |=> state_ff == ST_IDLE && memory_strobe_n)
    else $error("trailing cycle not closed");

  // consecutive mode opens every read with a starting step
  a_back_to_back_bank_mode_start: assert property (@(posedge pclk) disable iff (!presetn)
    (s_take ##0 (back_to_back_bank_mode_ff && core_req.is_read)) |=> s_gap_step)
    else $error("no starting cycle");

  // a gap step always leads into the read step one tick later
  a_gap_then_read: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_tick && state_ff == ST_GAP) |=> s_read_step)
    else $error("gap not followed by read");

  // the address moves to the new value during the gap
  a_gap_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (s_take ##0 need_gap) |=> ext_addr == $past(core_req.addr[ADDR_W-1:0]))
    else $error("address not moved in gap");

  // data read after a program read
  a_space_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (s_take ##0 (core_req.is_read && !core_req.is_prog
                 && last_space_ff == bsk_pkg::BSK_SPACE_PROG)) |=> s_gap_step)
    else $error("no gap on space swap");

  // program read on a new page after a program read
  a_page_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (s_take ##0 (core_req.is_read && core_req.is_prog
                 && last_space_ff == bsk_pkg::BSK_SPACE_PROG
                 && core_req.addr[ADDR_W-1:16] != last_page_ff)) |=> s_gap_step)
    else $error("no gap on page change");

  // the read step ends with strobe off and a one cycle accept
  a_read_close: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_tick && state_ff == ST_ACCESS) |=> memory_strobe_n && req_accept)
    else $error("read step not closed");

  // accept never stretches, so the core cannot be taken twice
  a_accept_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    req_accept |=> !req_accept)
    else $error("accept longer than one cycle");

  // apb answers with a single ready cycle and never an error
  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready longer than one cycle");

  a_no_error: assert property (@(posedge pclk) disable iff (!presetn)
    !pslverr)
    else $error("slave error raised");

  // divider field written from its own bit positions
  a_write_div: assert property (@(posedge pclk) disable iff (!presetn)
    wr_hit |=> clock_out_divider_ff == $past(pwdata[14:13]))
    else $error("divider not written");

  // read back of the divider field during an access cycle
  a_read_div: assert property (@(posedge pclk) disable iff (!presetn)
    rd_hit |=> prdata[14:13] == $past(clock_out_divider_ff))
    else $error("divider read back wrong");

  // ack switch bit written from bit 12
  a_write_intack: assert property (@(posedge pclk) disable iff (!presetn)
    wr_hit |=> intack_output_off_ff == $past(pwdata[12]))
    else $error("ack switch not written");

  // with the off bit clear the ack follows the core, low active
  a_ack_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 !$past(intack_output_off_ff) |-> interrupt_ack_out == !$past(core_intack))
    else $error("ack not following core");

  // keeper bits written from bits 2 and 1
  a_write_keep: assert property (@(posedge pclk) disable iff (!presetn)
    wr_hit |=> data_bus_keeper_en_ff == $past(pwdata[1])
               && host_bus_keeper_en_ff == $past(pwdata[2]))
    else $error("keeper bits not written");

  // address keeper follows the wide pin or the host bit
  a_addr_keeper: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 keep_en.addr_keep == ($past(host_bus_keeper_en_ff) || $past(wide_sync2_ff)))
    else $error("address keeper wrong");
endmodule // bsk_ctrl

// ---- shared/bsk_consts.svh ----
// bank switch / bus keeper control: offsets, field positions, reset values
// assumes inclusion by the bank switch controller only
`ifndef BSK_CONSTS_SVH
`define BSK_CONSTS_SVH
// -----------------------------------------------------------------------
// register map
// -----------------------------------------------------------------------
`define BSK_REG_INDEX 8'h29
`define BSK_REG_ADDR 12'h0a4
`define BSK_BIT_MODE 15
`define BSK_BIT_DIV_HI 14
`define BSK_BIT_DIV_LO 13
`define BSK_BIT_INTACK_OFF 12
`define BSK_BIT_HOST_KEEP 2
`define BSK_BIT_DATA_KEEP 1
`define BSK_RST_DIV 2'h3
`define BSK_RST_INTACK_OFF 1'b1
`define BSK_BANK_MSB 15
`endif

// ---- shared/bsk_pkg.sv ----
// bank switch controller types
// assumes nothing beyond the header of constants
package bsk_pkg;
  // -----------------------------------------------------------------------
  // types
  // -----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BSK_SPACE_PROG,
    BSK_SPACE_DATA,
    BSK_SPACE_NONE
  } bsk_space_e;

  // one external access request from the core
  typedef struct packed {
    logic valid;
    logic is_read;
    logic is_prog;
    logic [22:0] addr;
  } bsk_req_s;

  // keeper enables, high means keeper on
  typedef struct packed {
    logic data_keep;
    logic addr_keep;
    logic host_keep;
  } bsk_keep_s;
endpackage

// ---- dv/bsk_mem_model.sv ----
// external memory stand-in: counts strobe cycles, keeps last address
// assumes a low active strobe and the controller's single clock
`timescale 1ns/1ns
module bsk_mem_model #(
  parameter int AW = 23
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // memory pins
  input wire logic memory_strobe_n,
  input wire logic [AW-1:0] ext_addr,
  // observation
  output logic [15:0] stb_cnt_ff,
  output logic [AW-1:0] addr_ff
);
  // each low strobe cycle is one memory cycle; address taken with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_cnt_ff <= '0;
      addr_ff <= '0;
    end else if (!memory_strobe_n) begin
      stb_cnt_ff <= stb_cnt_ff + 16'h0001;
      addr_ff <= ext_addr;
    end
  end
endmodule // bsk_mem_model

// ---- dv/bsk_ctrl_tb_top.sv ----
// bench for the bank switch controller: apb, core requests, pins
// assumes zero wait apb and divider 0 during core timing checks
`timescale 1ns/1ns
module bsk_ctrl_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  bsk_pkg::bsk_req_s req;
  bsk_pkg::bsk_keep_s keep;
  logic intack, accept, stb_n, clk_out, ack_n, wide;
  logic [22:0] ext_addr, m_addr;
  logic [15:0] m_cnt, c0;
  int failures, tests_run, cyc;
  bsk_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_req(req), .core_intack(intack), .req_accept(accept),
    .memory_strobe_n(stb_n), .ext_addr(ext_addr), .clock_out_pin(clk_out),
    .interrupt_ack_out(ack_n), .wide_host_port_sel(wide), .keep_en(keep));
  bsk_mem_model u_mem (.pclk(pclk), .presetn(presetn), .memory_strobe_n(stb_n),
    .ext_addr(ext_addr), .stb_cnt_ff(m_cnt), .addr_ff(m_addr));
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard: runs take well under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task finish_test;
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // outputs looked at mid cycle, where they have settled
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    chk("pready", 32'h1, 32'(pready));
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // one core access; measures cycles to strobe low and to accept
  task core(input logic p, input logic r, input logic [22:0] a, input int es, input int ea);
    int n, s;
    req <= '{1'b1, r, p, a};
    n = 0;
    s = 0;
    do begin
      @(negedge pclk);
      n++;
      if (stb_n === 1'b0 && s == 0) begin
        s = n;
        if (es > 0) chk("ext_addr", 32'(a), 32'(ext_addr));
      end
    end while (accept !== 1'b1 && n < 40);
    @(posedge pclk);
    req <= '0;
    @(posedge pclk);
    if (es > 0) begin
      chk("strobe delay", 32'(es), 32'(s));
      chk("accept delay", 32'(ea), 32'(n));
    end
  endtask
  task t_regs;
    apb(1'b0, 12'h0a4, 32'h0);
    chk("reset value", 32'h0000_7000, rd);
    apb(1'b1, 12'h0a4, 32'hffff_ffff);
    apb(1'b0, 12'h0a4, 32'h0);
    chk("reserved bits", 32'h0000_f006, rd);
    apb(1'b0, 12'h0a0, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("pslverr", 32'h0, 32'(pslverr));
  endtask
  // all eight keeper combinations; wide pin passes a two stage sync
  task t_keep;
    for (int i = 0; i < 8; i++) begin
      wide <= i[2];
      apb(1'b1, 12'h0a4, 32'(i[1:0]) << 1);
      repeat (3) @(posedge pclk);
      chk("keepers", {29'h0, i[0], i[2] | i[1], i[2] | i[1]}, {29'h0, keep});
    end
    wide <= 1'b0;
  endtask
  task t_div;
    int e;
    logic q;
    for (int d = 1; d < 4; d++) begin
      apb(1'b1, 12'h0a4, 32'(d) << 13);
      repeat (8) @(posedge pclk);
      @(negedge pclk);
      e = 0;
      q = clk_out;
      repeat (24) begin
        @(negedge pclk);
        if (clk_out === 1'b1 && q === 1'b0) e++;
        q = clk_out;
      end
      @(posedge pclk);
      chk("clock out edges", 32'(24 / (d + 1)), 32'(e));
    end
  endtask
  task t_intack;
    intack <= 1'b1;
    apb(1'b1, 12'h0a4, 32'h0000_1000);
    repeat (3) @(posedge pclk);
    chk("intack off", 32'h1, 32'(ack_n));
    apb(1'b1, 12'h0a4, 32'h0);
    repeat (3) @(posedge pclk);
    chk("intack on", 32'h0, 32'(ack_n));
    intack <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("intack idle", 32'h1, 32'(ack_n));
  endtask
  task t_bank;
    core(1'b1, 1'b1, 23'h00_0100, 0, 0);
    core(1'b1, 1'b1, 23'h00_0200, 2, 3);
    core(1'b1, 1'b1, 23'h00_8000, 3, 4);
    core(1'b1, 1'b1, 23'h00_8010, 2, 3);
    core(1'b0, 1'b1, 23'h00_8020, 3, 4);
    core(1'b1, 1'b1, 23'h00_8030, 3, 4);
    core(1'b1, 1'b1, 23'h01_8030, 3, 4);
    core(1'b0, 1'b0, 23'h00_0000, 0, 0);
    core(1'b0, 1'b1, 23'h00_0010, 2, 3);
  endtask
  // start, read and trail cycles on every read, one strobe each
  task t_back_to_back_bank_mode;
    apb(1'b1, 12'h0a4, 32'h0000_8000);
    c0 = m_cnt;
    core(1'b1, 1'b1, 23'h00_0140, 3, 4);
    core(1'b1, 1'b1, 23'h00_0144, 3, 4);
    chk("strobe cycles", 32'h2, 32'(m_cnt - c0));
    chk("memory addr", 32'h0000_0144, 32'(m_addr));
    apb(1'b1, 12'h0a4, 32'h0);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    req = '0;
    intack = 1'b0;
    wide = 1'b0;
    failures = 0;
    tests_run = 0;
    cyc = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_keep();
    t_div();
    t_intack();
    t_bank();
    t_back_to_back_bank_mode();
    finish_test();
  end
endmodule // bsk_ctrl_tb_top
